// ==== core/ssc_regs.svh ====
// Register offsets, field positions, codes and schedule constants of the slow-channel scheduler.
`ifndef SSC_REGS_SVH
`define SSC_REGS_SVH
`define SSC_OFS_CTRL 7'h00
`define SSC_OFS_SET2 7'h04
`define SSC_OFS_HI 7'h08
`define SSC_OFS_LO 7'h0c
`define SSC_OFS_STYPE 7'h10
`define SSC_OFS_SID 7'h14
`define SSC_OFS_SREV 7'h18
`define SSC_OFS_STAT 7'h1c
`define SSC_OFS_OEM0 7'h20
`define SSC_OFS_OEM7 7'h3c
`define SSC_CTRL_EN 0
`define SSC_CTRL_PW 1
`define SSC_CTRL_SBE 10
`define SSC_CTRL_DIAG 14
`define SSC_CTRL_RST 16'h0000
`define SSC_SET2_RST 16'h0000
`define SSC_NSLOT 5'd18
`define SSC_LAST 5'd17
`define SSC_SYNC_LEN 5'd6
`define SSC_ID_DIAG 8'h01
`define SSC_ID_TEMP 8'h23
`define SSC_ID_VDD 8'h1c
`define SSC_ID_TYPE 8'h03
`define SSC_ID_SID 8'h29
`define SSC_ID_MFR 8'h05
`define SSC_ID_REV 8'h06
`define SSC_ID_OEM0 8'h90
`define SSC_OEM_SLOT 5'd10
`define SSC_DC_OK 12'h000
`define SSC_DC_HI 12'h001
`define SSC_DC_LO 12'h002
`define SSC_DC_UV 12'h020
`define SSC_DC_OV 12'h021
`define SSC_DC_TEMP 12'h022
`define SSC_DC_SBE 12'h023
`define SSC_DC_SAFE_MIN 12'h801
`define SSC_CRC_SEED 6'h15
`define SSC_CRC_POLY 6'h19
`define SSC_UV_TH0 9'h0c8
`define SSC_UV_TH1 9'h0d2
`define SSC_UV_TH2 9'h0dc
`define SSC_UV_TH3 9'h0e6
`define SSC_OV_TH0 9'h190
`define SSC_OV_TH1 9'h1a4
`define SSC_OV_TH2 9'h1b8
`define SSC_OV_TH3 9'h1cc
`endif

// ==== core/ssc_pkg.sv ====
// Types of the slow-channel scheduler.
`default_nettype none
package ssc_pkg;
  typedef enum logic {SSC_IDLE, SSC_RUN} ssc_mode_e;
  typedef struct packed {
    ssc_mode_e mode;
    logic [15:0] ctrl;
    logic [15:0] set2;
    logic [11:0] hi;
    logic [11:0] lo;
    logic [11:0] stype;
    logic [11:0] sid;
    logic [11:0] srev;
    logic [7:0][11:0] oem;
    logic [4:0] slot;
    logic [4:0] frame;
    logic [7:0] msg_id;
    logic [11:0] msg_data;
    logic [5:0] msg_crc;
    logic [11:0] diag_code;
    logic bit1;
    logic bit2;
    logic bit3;
    logic ack;
    logic [31:0] rdata;
  } ssc_state_s;
endpackage
`default_nettype wire

// ==== core/ssc_top.sv ====
// Slow serial channel scheduler with Avalon-MM register slave.
//
// Notes on behaviour
// - Slow channel rides on status nibble bits 2 and 3 of every frame.
// - One message spans 18 consecutive frames; receiver collects all 18.
// - Enhanced format: 8-bit message identifier, 12-bit data.
// - While enabled the schedule repeats, wrapping from slot 18 to slot 1.
// - Slots 1-10 send 01h,23h,1Ch,03h,29h,05h,06h,01h,23h,1Ch.
// - Slots 11-18 send user codes with identifiers 90h to 97h.
// - Diagnostic code 000h normally, 001h above the upper range limit.
// - Diagnostic code 002h below the lower range limit.
// - Code 020h under the undervoltage threshold chosen by setting bits 13:12.
// - Code 021h over the overvoltage threshold chosen by setting bits 15:14.
// - Code 022h over temperature limit bits 11:7; 023h on single-bit error.
// - Those conditions also raise status bit 1 when pre-warning is on.
// - Codes 801h-FFFh are safety field; reserved codes are never sent.
// - Safety field bit 11 mirrors the diagnostic-mode control bit 14.
// - Safety bits 10..6: angle range, CORDIC, adder, converter, self-test encoding.
// - Safety bit 5: control-signal check or incomplete self-test.
// - Safety bits 4, 3, 2: adjusted angle, conversion, division checks.
// - Safety bit 1: inverted angle check; bit 0: field conversion check.
`timescale 1ns/1ns
`default_nettype none
`include "ssc_regs.svh"
module ssc_top #(
  parameter logic [11:0] MFR_CODE = 12'h000 // Arbitrary neutral value.
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Frame pacing and measurements
  input wire logic frame_tick,
  input wire logic [11:0] out_value,
  input wire logic [8:0] supply_code,
  input wire logic [7:0] temp_code,
  input wire logic mem_single_bit_err,
  input wire logic [10:0] check_fail,
  // Status nibble bits
  output logic status_bit1,
  output logic status_bit2,
  output logic status_bit3
);
  import ssc_pkg::*;

  ssc_state_s r;
  ssc_state_s n;

  function automatic logic [7:0] ssc_sched_id(input logic [4:0] s);
    case (s)
      5'd0, 5'd7: ssc_sched_id = `SSC_ID_DIAG;
      5'd1, 5'd8: ssc_sched_id = `SSC_ID_TEMP;
      5'd2, 5'd9: ssc_sched_id = `SSC_ID_VDD;
      5'd3: ssc_sched_id = `SSC_ID_TYPE;
      5'd4: ssc_sched_id = `SSC_ID_SID;
      5'd5: ssc_sched_id = `SSC_ID_MFR;
      5'd6: ssc_sched_id = `SSC_ID_REV;
      default: ssc_sched_id = `SSC_ID_OEM0 + {3'h0, s - `SSC_OEM_SLOT};
    endcase
  endfunction

  // Bit 3 carries the sync run, the config bit and the identifier nibbles.
  function automatic logic ssc_b3(input logic [4:0] f, input logic [7:0] id);
    if (f < `SSC_SYNC_LEN) begin
      ssc_b3 = 1'b1;
    end else if (f >= 5'd8 && f <= 5'd11) begin
      ssc_b3 = id[3'(5'd15 - f)];
    end else if (f >= 5'd13 && f <= 5'd16) begin
      ssc_b3 = id[3'(5'd16 - f)];
    end else begin
      ssc_b3 = 1'b0;
    end
  endfunction

  function automatic logic ssc_b2(input logic [4:0] f, input logic [11:0] d, input logic [5:0] c);
    if (f < `SSC_SYNC_LEN) begin
      ssc_b2 = c[3'(5'd5 - f)];
    end else begin
      ssc_b2 = d[4'(5'd17 - f)];
    end
  endfunction

  // CRC-6 over bits 2 and 3 of frames 7 to 18, bit 2 first in each frame.
  function automatic logic [5:0] ssc_crc(input logic [7:0] id, input logic [11:0] d);
    logic [5:0] c;
    logic fb;
    c = `SSC_CRC_SEED;
    fb = 1'b0;
    for (int i = 6; i < 18; i++) begin
      fb = c[5] ^ d[17 - i];
      c = {c[4:0], 1'b0} ^ (fb ? `SSC_CRC_POLY : 6'h00);
      fb = c[5] ^ ssc_b3(5'(i), id);
      c = {c[4:0], 1'b0} ^ (fb ? `SSC_CRC_POLY : 6'h00);
    end
    ssc_crc = c;
  endfunction

  function automatic logic [31:0] ssc_merge(input logic [31:0] o, input logic [31:0] w, input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        o[b*8 +: 8] = w[b*8 +: 8];
      end
    end
    ssc_merge = o;
  endfunction

  // Live diagnostic conditions.
  logic [8:0] uv_th;
  logic [8:0] ov_th;
  logic c_hi, c_lo, c_uv, c_ov, c_temp, c_sbe;
  logic [11:0] safety_field;
  logic [11:0] diag_live;
  logic [4:0] idx;
  logic [31:0] rd_mux;

  always_comb begin
    case (r.set2[13:12])
      2'd0: uv_th = `SSC_UV_TH0;
      2'd1: uv_th = `SSC_UV_TH1;
      2'd2: uv_th = `SSC_UV_TH2;
      default: uv_th = `SSC_UV_TH3;
    endcase
    case (r.set2[15:14])
      2'd0: ov_th = `SSC_OV_TH0;
      2'd1: ov_th = `SSC_OV_TH1;
      2'd2: ov_th = `SSC_OV_TH2;
      default: ov_th = `SSC_OV_TH3;
    endcase
  end

  assign c_hi = out_value > r.hi;
  assign c_lo = out_value < r.lo;
  assign c_uv = supply_code < uv_th;
  assign c_ov = supply_code > ov_th;
  assign c_temp = temp_code[7:3] > r.set2[11:7];
  assign c_sbe = mem_single_bit_err | r.ctrl[`SSC_CTRL_SBE];
  // Fail bits map straight onto field bits 10..0.
  assign safety_field = {r.ctrl[`SSC_CTRL_DIAG], check_fail};

  // Safety errors outrank supply, then temperature, memory and range.
  // Diagnostic mode without a failing check would give 800h, which is reserved, so it is not sent.
  always_comb begin
    if (safety_field >= `SSC_DC_SAFE_MIN) begin
      diag_live = safety_field;
    end else if (c_uv) begin
      diag_live = `SSC_DC_UV;
    end else if (c_ov) begin
      diag_live = `SSC_DC_OV;
    end else if (c_temp) begin
      diag_live = `SSC_DC_TEMP;
    end else if (c_sbe) begin
      diag_live = `SSC_DC_SBE;
    end else if (c_hi) begin
      diag_live = `SSC_DC_HI;
    end else if (c_lo) begin
      diag_live = `SSC_DC_LO;
    end else begin
      diag_live = `SSC_DC_OK;
    end
  end

  assign idx = avs_address[6:2];

  always_comb begin
    case ({avs_address[6:2], 2'b00})
      `SSC_OFS_CTRL: rd_mux = {16'h0000, r.ctrl};
      `SSC_OFS_SET2: rd_mux = {16'h0000, r.set2};
      `SSC_OFS_HI: rd_mux = {20'h00000, r.hi};
      `SSC_OFS_LO: rd_mux = {20'h00000, r.lo};
      `SSC_OFS_STYPE: rd_mux = {20'h00000, r.stype};
      `SSC_OFS_SID: rd_mux = {20'h00000, r.sid};
      `SSC_OFS_SREV: rd_mux = {20'h00000, r.srev};
      `SSC_OFS_STAT: rd_mux = {r.msg_id, r.diag_code, 1'b0, r.slot, r.frame, r.mode};
      default: begin
        if (idx >= (`SSC_OFS_OEM0 >> 2) && idx <= (`SSC_OFS_OEM7 >> 2)) begin
          rd_mux = {20'h00000, r.oem[idx[2:0]]};
        end else begin
          rd_mux = 32'h00000000;
        end
      end
    endcase
  end

  always_comb begin
    logic load;
    logic [4:0] ls;
    logic [31:0] wv;
    load = 1'b0;
    ls = 5'd0;
    wv = 32'h00000000;
    n = r;
    n.ack = 1'b0;
    // Every access waits one cycle so read data always comes from a flop.
    if ((avs_read || avs_write) && !r.ack) begin
      n.ack = 1'b1;
      n.rdata = rd_mux;
    end
    if (avs_write && r.ack) begin
      case ({avs_address[6:2], 2'b00})
        `SSC_OFS_CTRL: begin
          wv = ssc_merge({16'h0000, r.ctrl}, avs_writedata, avs_byteenable);
          n.ctrl = wv[15:0];
        end
        `SSC_OFS_SET2: begin
          wv = ssc_merge({16'h0000, r.set2}, avs_writedata, avs_byteenable);
          n.set2 = wv[15:0];
        end
        `SSC_OFS_HI: begin
          wv = ssc_merge({20'h00000, r.hi}, avs_writedata, avs_byteenable);
          n.hi = wv[11:0];
        end
        `SSC_OFS_LO: begin
          wv = ssc_merge({20'h00000, r.lo}, avs_writedata, avs_byteenable);
          n.lo = wv[11:0];
        end
        `SSC_OFS_STYPE: begin
          wv = ssc_merge({20'h00000, r.stype}, avs_writedata, avs_byteenable);
          n.stype = wv[11:0];
        end
        `SSC_OFS_SID: begin
          wv = ssc_merge({20'h00000, r.sid}, avs_writedata, avs_byteenable);
          n.sid = wv[11:0];
        end
        `SSC_OFS_SREV: begin
          wv = ssc_merge({20'h00000, r.srev}, avs_writedata, avs_byteenable);
          n.srev = wv[11:0];
        end
        default: begin
          if (idx >= (`SSC_OFS_OEM0 >> 2) && idx <= (`SSC_OFS_OEM7 >> 2)) begin
            wv = ssc_merge({20'h00000, r.oem[idx[2:0]]}, avs_writedata, avs_byteenable);
            n.oem[idx[2:0]] = wv[11:0];
          end
        end
      endcase
    end
    // Schedule sequencing, advanced once per emitted frame.
    if (!r.ctrl[`SSC_CTRL_EN]) begin
      n.mode = SSC_IDLE;
    end else if (r.mode == SSC_IDLE) begin
      n.mode = SSC_RUN;
      load = 1'b1;
      ls = 5'd0;
    end else if (frame_tick) begin
      if (r.frame == `SSC_LAST) begin
        load = 1'b1;
        ls = (r.slot == `SSC_LAST) ? 5'd0 : r.slot + 5'd1;
      end else begin
        n.frame = r.frame + 5'd1;
      end
    end
    if (load) begin
      n.slot = ls;
      n.frame = 5'd0;
      n.msg_id = ssc_sched_id(ls);
      case (ls)
        5'd0, 5'd7: begin
          n.diag_code = diag_live;
          n.msg_data = diag_live;
        end
        5'd1, 5'd8: n.msg_data = {4'h0, temp_code};
        5'd2, 5'd9: n.msg_data = {3'h0, supply_code};
        5'd3: n.msg_data = r.stype;
        5'd4: n.msg_data = r.sid;
        5'd5: n.msg_data = MFR_CODE;
        5'd6: n.msg_data = r.srev;
        default: n.msg_data = r.oem[3'(ls - `SSC_OEM_SLOT)];
      endcase
      n.msg_crc = ssc_crc(n.msg_id, n.msg_data);
    end
    if (n.mode == SSC_RUN) begin
      n.bit2 = ssc_b2(n.frame, n.msg_data, n.msg_crc);
      n.bit3 = ssc_b3(n.frame, n.msg_id);
    end else begin
      n.bit2 = 1'b0;
      n.bit3 = 1'b0;
    end
    n.bit1 = r.ctrl[`SSC_CTRL_PW] & (c_hi | c_lo | c_uv | c_ov | c_temp | c_sbe);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r <= '0;
      r.mode <= SSC_IDLE;
      r.ctrl <= `SSC_CTRL_RST;
      r.set2 <= `SSC_SET2_RST;
    end else begin
      r <= n;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~r.ack;
  assign avs_readdata = r.rdata;
  assign status_bit1 = r.bit1;
  assign status_bit2 = r.bit2;
  assign status_bit3 = r.bit3;

  property p_disabled_quiet;
    @(posedge clk) disable iff (reset) !r.ctrl[`SSC_CTRL_EN] |=> !status_bit2 && !status_bit3;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("slow bits active while disabled");

  property p_frame_range;
    @(posedge clk) disable iff (reset) r.frame < `SSC_NSLOT && r.slot < `SSC_NSLOT;
  endproperty
  a_frame_range: assert property (p_frame_range) else $error("frame or slot index out of range");

  property p_wrap;
    @(posedge clk) disable iff (reset)
      r.mode == SSC_RUN && r.ctrl[`SSC_CTRL_EN] && frame_tick && r.frame == 5'd17 && r.slot == 5'd17
      |=> r.slot == 5'd0 && r.frame == 5'd0 && r.msg_id == 8'h01;
  endproperty
  a_wrap: assert property (p_wrap) else $error("schedule did not restart at slot one");

  property p_sched_fixed;
    @(posedge clk) disable iff (reset)
      r.mode == SSC_RUN && (r.slot == 5'd1 || r.slot == 5'd8) |-> r.msg_id == 8'h23;
  endproperty
  a_sched_fixed: assert property (p_sched_fixed) else $error("temperature slot carries wrong identifier");

  property p_sched_oem;
    @(posedge clk) disable iff (reset)
      r.mode == SSC_RUN && r.slot >= 5'd10 |-> r.msg_id == 8'h90 + {3'h0, r.slot - 5'd10};
  endproperty
  a_sched_oem: assert property (p_sched_oem) else $error("user code slot carries wrong identifier");

  property p_no_reserved;
    @(posedge clk) disable iff (reset)
      !((r.diag_code >= 12'h003 && r.diag_code <= 12'h019) || (r.diag_code >= 12'h024 && r.diag_code <= 12'h800));
  endproperty
  a_no_reserved: assert property (p_no_reserved) else $error("reserved diagnostic code latched");

  property p_safety_msb;
    @(posedge clk) disable iff (reset)
      r.ctrl[`SSC_CTRL_DIAG] && check_fail != 11'h000 |-> diag_live == {1'b1, check_fail};
  endproperty
  a_safety_msb: assert property (p_safety_msb) else $error("safety field not reported");

  property p_prewarn;
    @(posedge clk) disable iff (reset)
      r.ctrl[`SSC_CTRL_PW] && c_ov |=> status_bit1;
  endproperty
  a_prewarn: assert property (p_prewarn) else $error("pre-warning bit not raised");

  property p_code_held;
    @(posedge clk) disable iff (reset)
      r.mode == SSC_RUN && r.frame != 5'd17 && r.ctrl[`SSC_CTRL_EN] |=> $stable(r.diag_code) && $stable(r.msg_data);
  endproperty
  a_code_held: assert property (p_code_held) else $error("message content changed mid message");

  property p_sync_run;
    @(posedge clk) disable iff (reset)
      r.mode == SSC_RUN && r.frame < `SSC_SYNC_LEN
      |-> status_bit3;
  endproperty
  a_sync_run: assert property (p_sync_run) else $error("sync run bit missing");

  c_wrap: cover property (@(posedge clk) disable iff (reset) r.slot == 5'd17 ##1 r.slot == 5'd0);
  c_safety: cover property (@(posedge clk) disable iff (reset) r.diag_code >= 12'h801);
  c_hi_code: cover property (@(posedge clk) disable iff (reset) r.diag_code == 12'h001);
endmodule // ssc_top
`default_nettype wire

// ==== verification/ssc_sent_rx.sv ====
// Behavioural SENT receiver that reassembles slow-channel messages from the status nibble bits.
`timescale 1ns/1ns
`default_nettype none
module ssc_sent_rx (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Frame pacing and status nibble bits
  input wire logic frame_tick,
  input wire logic status_bit2,
  input wire logic status_bit3,
  // Last reassembled message
  output logic [7:0] rx_id,
  output logic [11:0] rx_data,
  output logic rx_crc_ok,
  output logic [15:0] rx_count
);
  logic [17:0] sh2_reg;
  logic [17:0] sh3_reg;

  // Index 17 holds the oldest frame, so frames 6..17 sit at indices 11..0.
  function automatic logic [5:0] crc6(input logic [17:0] b2, input logic [17:0] b3);
    logic [5:0] c;
    logic fb;
    c = 6'h15;
    for (int f = 11; f >= 0; f--) begin
      fb = c[5] ^ b2[f];
      c = {c[4:0], 1'b0} ^ (fb ? 6'h19 : 6'h00);
      fb = c[5] ^ b3[f];
      c = {c[4:0], 1'b0} ^ (fb ? 6'h19 : 6'h00);
    end
    return c;
  endfunction

  always_ff @(posedge clk) begin : rx_proc
    logic [17:0] n2;
    logic [17:0] n3;
    if (reset) begin
      sh2_reg <= 18'h00000;
      sh3_reg <= 18'h00000;
      rx_id <= 8'h00;
      rx_data <= 12'h000;
      rx_crc_ok <= 1'b0;
      rx_count <= 16'h0000;
    end else if (frame_tick) begin
      n2 = {sh2_reg[16:0], status_bit2};
      n3 = {sh3_reg[16:0], status_bit3};
      sh2_reg <= n2;
      sh3_reg <= n3;
      // Six ones then two zeros can only line up at frame 0 of a message.
      if (n3[17:12] == 6'h3f && n3[11:10] == 2'b00 && n3[5] == 1'b0 && n3[0] == 1'b0) begin
        rx_id <= {n3[9:6], n3[4:1]};
        rx_data <= n2[11:0];
        rx_crc_ok <= (crc6(n2, n3) == n2[17:12]);
        rx_count <= rx_count + 16'h0001;
      end
    end
  end
endmodule // ssc_sent_rx
`default_nettype wire

// ==== verification/sent_slow_channel_scheduler_test.sv ====
// Self-checking bench of the slow-channel scheduler.
`timescale 1ns/1ns
`default_nettype none
`include "ssc_regs.svh"
module sent_slow_channel_scheduler_test;
  import ssc_pkg::*;
  logic clk, reset, avs_read, avs_write, avs_waitrequest, frame_tick, mem_single_bit_err;
  logic [6:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic [11:0] out_value, rx_data;
  logic [8:0] supply_code;
  logic [7:0] temp_code, rx_id;
  logic [10:0] check_fail;
  logic status_bit1, status_bit2, status_bit3, rx_crc_ok;
  logic [15:0] rx_count;
  logic [15:0] cnt;
  int err_count, compares, slot_no;
  logic [7:0] exp_ids [18] = '{8'h01, 8'h23, 8'h1c, 8'h03, 8'h29, 8'h05, 8'h06, 8'h01, 8'h23, 8'h1c,
    8'h90, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97};

  ssc_top dut (.clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .frame_tick(frame_tick),
    .out_value(out_value), .supply_code(supply_code), .temp_code(temp_code),
    .mem_single_bit_err(mem_single_bit_err), .check_fail(check_fail), .status_bit1(status_bit1),
    .status_bit2(status_bit2), .status_bit3(status_bit3));
  ssc_sent_rx u_rx (.clk(clk), .reset(reset), .frame_tick(frame_tick), .status_bit2(status_bit2),
    .status_bit3(status_bit3), .rx_id(rx_id), .rx_data(rx_data), .rx_crc_ok(rx_crc_ok), .rx_count(rx_count));

  task automatic close_out();
    if (err_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  // The request stands until waitrequest is seen low at a rising edge; that edge completes it.
  task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      if (n > 50) begin
        check(1'b0, "bus timeout");
        close_out();
      end
      @(posedge clk);
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    logic [31:0] unused;
    bus(1'b1, a, d, unused);
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [31:0] e);
    logic [31:0] d;
    bus(1'b0, a, 32'h0000_0000, d);
    check(d === e, "register readback");
  endtask

  task automatic tick();
    @(posedge clk);
    frame_tick <= 1'b1;
    @(posedge clk);
    frame_tick <= 1'b0;
  endtask

  task automatic set_in(input logic [11:0] ov, input logic [8:0] sv, input logic [7:0] tv, input logic sb,
    input logic [10:0] cf);
    out_value <= ov;
    supply_code <= sv;
    temp_code <= tv;
    mem_single_bit_err <= sb;
    check_fail <= cf;
  endtask

  // One whole message; with clr the inputs return to normal half way through it.
  task automatic run_msg(input logic clr);
    cnt = rx_count;
    for (int i = 0; i < 18; i++) begin
      if (clr && i == 9) set_in(12'h400, 9'h100, 8'h50, 1'b0, 11'h000);
      tick();
    end
    @(negedge clk);
    check(rx_count === cnt + 16'h0001, "message not framed");
    check(rx_id === exp_ids[slot_no], "wrong message id");
    check(rx_crc_ok === 1'b1, "bad message crc");
    if (slot_no >= 10) check(rx_data === 12'h5a0 + 12'(slot_no - 10), "user code data");
    slot_no = (slot_no + 1) % 18;
  endtask

  task automatic diag_case(input logic [11:0] ov, input logic [8:0] sv, input logic [7:0] tv, input logic sb,
    input logic [10:0] cf, input logic pw, input logic [11:0] exp, input logic hold);
    @(posedge clk);
    set_in(ov, sv, tv, sb, cf);
    repeat (3) @(posedge clk);
    @(negedge clk);
    check(status_bit1 === pw, "pre-warning bit");
    run_msg(1'b0);
    while (slot_no != 0 && slot_no != 7) run_msg(1'b0);
    run_msg(hold);
    check(rx_data === exp, "diagnostic code");
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    reset = 1'b1;
    avs_address = 7'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hf;
    frame_tick = 1'b0;
    out_value = 12'h400;
    supply_code = 9'h100;
    temp_code = 8'h50;
    mem_single_bit_err = 1'b0;
    check_fail = 11'h000;
    err_count = 0;
    compares = 0;
    slot_no = 0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    check({status_bit3, status_bit2, status_bit1} === 3'b000, "outputs after reset");
    rd_chk(`SSC_OFS_CTRL, 32'h0000_0000);
    rd_chk(`SSC_OFS_SET2, 32'h0000_0000);
    wr(`SSC_OFS_HI, 32'hffff_f800);
    rd_chk(`SSC_OFS_HI, 32'h0000_0800);
    wr(`SSC_OFS_LO, 32'h0000_0100);
    // Undervoltage select 1, overvoltage select 2, temperature limit 20.
    wr(`SSC_OFS_SET2, 32'h0000_9a00);
    wr(7'h44, 32'hffff_ffff);
    rd_chk(7'h44, 32'h0000_0000);
    for (int i = 0; i < 8; i++) wr(`SSC_OFS_OEM0 + 7'(4 * i), 32'h0000_05a0 + 32'(i));
    wr(`SSC_OFS_CTRL, 32'h0000_4003);
    repeat (19) run_msg(1'b0);
    diag_case(12'h900, 9'h100, 8'h50, 1'b0, 11'h000, 1'b1, 12'h001, 1'b1);
    diag_case(12'h080, 9'h100, 8'h50, 1'b0, 11'h000, 1'b1, 12'h002, 1'b0);
    diag_case(12'h400, 9'h0d1, 8'h50, 1'b0, 11'h000, 1'b1, 12'h020, 1'b0);
    diag_case(12'h400, 9'h1b9, 8'h50, 1'b0, 11'h000, 1'b1, 12'h021, 1'b0);
    diag_case(12'h400, 9'h100, 8'ha8, 1'b0, 11'h000, 1'b1, 12'h022, 1'b0);
    diag_case(12'h400, 9'h100, 8'h50, 1'b1, 11'h000, 1'b1, 12'h023, 1'b0);
    diag_case(12'h900, 9'h0d1, 8'ha8, 1'b1, 11'h000, 1'b1, 12'h020, 1'b0);
    diag_case(12'h400, 9'h100, 8'h50, 1'b0, 11'h405, 1'b0, 12'hc05, 1'b0);
    diag_case(12'h400, 9'h0d1, 8'h50, 1'b0, 11'h3fa, 1'b1, 12'hbfa, 1'b0);
    diag_case(12'h400, 9'h100, 8'h50, 1'b0, 11'h000, 1'b0, 12'h000, 1'b0);
    // The software single-bit error flag alone must raise the same code as the input.
    wr(`SSC_OFS_CTRL, 32'h0000_4403);
    diag_case(12'h400, 9'h100, 8'h50, 1'b0, 11'h000, 1'b1, 12'h023, 1'b0);
    wr(`SSC_OFS_CTRL, 32'h0000_0000);
    repeat (3) @(posedge clk);
    @(negedge clk);
    check({status_bit3, status_bit2} === 2'b00, "channel not stopped");
    cnt = rx_count;
    repeat (18) tick();
    @(negedge clk);
    check(rx_count === cnt, "message while disabled");
    wr(`SSC_OFS_CTRL, 32'h0000_4003);
    slot_no = 0;
    run_msg(1'b0);
    close_out();
  end
endmodule // sent_slow_channel_scheduler_test
`default_nettype wire
